// ### sim/scc_core_model.sv
// core model: APB master for register reads and writes and sleep instruction pulses
// assumes the bench calls its tasks; signals move only just after pclk rises
module scc_core_model
    import scc_pkg::*;
(
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic sleep_instr
);
    timeunit 1ns;
    timeprecision 1ns;
    // bus idle and no sleep at start
    initial {psel, penable, pwrite, sleep_instr, paddr, pwdata} = '0;
    // one transfer, request held until pready is seen high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
    task automatic sleep_op();
        @(posedge pclk);
        sleep_instr <= 1'b1;
        @(posedge pclk);
        sleep_instr <= 1'b0;
    endtask
    // unlock, then write the bit inside the window
    task automatic set_brownout_sleep_off(input logic v);
        logic [31:0] q;
        logic e;
        xfer(1'b1, OFS_MICRO_CTRL, 32'h00000060, q, e);
        xfer(1'b1, OFS_MICRO_CTRL, {25'h0, v, 6'h00}, q, e);
    endtask
endmodule // scc_core_model

// ### sim/scc_sleep_ctrl_tb.sv
// bench for the sleep and clock divide controller
// assumes the core model drives APB and sleep pulses; 100 MHz pclk
module scc_sleep_ctrl_tb
    import scc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic fuse = 1'b0;
    logic sys_rst = 1'b0;
    logic xtal = 1'b1;
    logic t2_async = 1'b0;
    logic adc_en = 1'b1;
    logic psel, penable, pwrite, sleep_instr, pready, pslverr, err;
    logic div_tick, bod_on, core_hold, irq_resume, reset_vec_start, adc_start, comparator_pd;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    scc_wake_s wake = '0;
    scc_clk_s clk_en;
    int fails = 0;
    int compares = 0;
    always #5 pclk = ~pclk;
    scc_core_model scc_core_model_i (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleep_instr(sleep_instr));
    scc_sleep_ctrl #(.BOD_WAKE_CYC(20), .STARTUP_CYC(3)) scc_sleep_ctrl_i (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .divide_by_eight_fuse(fuse), .xtal_sel(xtal), .timer2_async(t2_async),
        .adc_enable(adc_en), .sleep_instr(sleep_instr), .sys_reset_req(sys_rst),
        .wake_src(wake), .clk_en(clk_en), .div_tick(div_tick), .bod_on(bod_on),
        .core_hold(core_hold), .irq_resume(irq_resume), .reset_vec_start(reset_vec_start),
        .adc_start(adc_start), .comparator_pd(comparator_pd));
    // compare and count
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %0h seen %0h", n, e, s);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic do_reset(input logic f);
        fuse <= f;
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask
    task automatic t_div();
        int n;
        do_reset(1'b1);
        scc_core_model_i.xfer(1'b0, OFS_CLK_DIV, 32'h0, q, err);
        check("div_fuse", q, 32'h3);
        do_reset(1'b0);
        scc_core_model_i.xfer(1'b0, OFS_CLK_DIV, 32'h0, q, err);
        check("div_plain", q, 32'h0);
        scc_core_model_i.xfer(1'b1, OFS_CLK_DIV, 32'hF, q, err);
        scc_core_model_i.xfer(1'b0, OFS_CLK_DIV, 32'h0, q, err);
        check("div_any", q, 32'hF);
        scc_core_model_i.xfer(1'b0, 8'h20, 32'h0, q, err);
        check("unmapped", err, 1'b1);
        scc_core_model_i.xfer(1'b1, OFS_CLK_DIV, 32'h2, q, err);
        repeat (8) @(posedge pclk);
        n = 0;
        repeat (16) @(posedge pclk) n += div_tick;
        check("div_ticks", n, 4);
        scc_core_model_i.xfer(1'b1, OFS_CLK_DIV, 32'h1, q, err);
        n = 0;
        repeat (16) @(posedge pclk) n += div_tick;
        check("div_two", n, 8);
        $display("test divider done");
    endtask
    // sleep in mode m, ignore nw, then wake on the external pin
    task automatic sleep_wake(input logic [2:0] m, input logic [6:0] ce, input int cyc,
            input logic bo, input scc_wake_s nw);
        int n;
        scc_core_model_i.xfer(1'b1, OFS_SLEEP_CTRL, {28'h0, m, 1'b1}, q, err);
        scc_core_model_i.sleep_op();
        #1;
        check("clk_en", clk_en, ce);
        check("bod_off", bod_on, bo);
        check("adc_start", adc_start, adc_en && m < 3'h2);
        @(posedge pclk);
        wake <= nw;
        repeat (3) @(posedge pclk);
        check("asleep", core_hold, 1'b1);
        wake <= nw | 9'h100;
        n = 0;
        do @(posedge pclk) n++; while (irq_resume !== 1'b1 && n < 60);
        wake <= '0;
        check("wake_cyc", n, cyc);
        check("bod_back", bod_on, 1'b1);
    endtask
    task automatic t_modes();
        sleep_wake(3'h0, 7'h1E, 7, 1'b1, '0);
        sleep_wake(3'h1, 7'h0E, 7, 1'b1, '0);
        sleep_wake(3'h2, 7'h00, 9, 1'b1, 9'h004);
        sleep_wake(3'h3, 7'h04, 9, 1'b1, '0);
        sleep_wake(3'h6, 7'h02, 12, 1'b1, '0);
        sleep_wake(3'h7, 7'h02, 12, 1'b1, '0);
        t2_async <= 1'b1;
        sleep_wake(3'h7, 7'h07, 12, 1'b1, '0);
        t2_async <= 1'b0;
        scc_core_model_i.xfer(1'b1, OFS_CMP_CTRL, 32'h80, q, err);
        adc_en <= 1'b0;
        #1;
        check("cmp_pd", comparator_pd, 1'b1);
        sleep_wake(3'h0, 7'h1E, 7, 1'b1, 9'h002);
        adc_en <= 1'b1;
        $display("test modes done");
    endtask
    task automatic t_noop();
        xtal <= 1'b0;
        scc_core_model_i.xfer(1'b1, OFS_SLEEP_CTRL, 32'h4, q, err);
        scc_core_model_i.sleep_op();
        #1;
        check("no_allow", {core_hold, clk_en}, 8'h7E);
        scc_core_model_i.xfer(1'b1, OFS_SLEEP_CTRL, 32'h9, q, err);
        scc_core_model_i.sleep_op();
        #1;
        check("reserved", {core_hold, clk_en}, 8'h7E);
        scc_core_model_i.xfer(1'b1, OFS_SLEEP_CTRL, 32'hD, q, err);
        scc_core_model_i.sleep_op();
        #1;
        check("no_xtal", {core_hold, clk_en}, 8'h7E);
        scc_core_model_i.xfer(1'b1, OFS_SLEEP_CTRL, 32'h1, q, err);
        scc_core_model_i.sleep_op();
        sys_rst <= 1'b1;
        @(posedge pclk);
        sys_rst <= 1'b0;
        #1;
        check("rst_vec", {core_hold, reset_vec_start}, 2'h1);
        $display("test noop done");
    endtask
    task automatic t_bod();
        scc_core_model_i.xfer(1'b1, OFS_MICRO_CTRL, 32'h40, q, err);
        scc_core_model_i.xfer(1'b0, OFS_MICRO_CTRL, 32'h0, q, err);
        check("brownout_sleep_off_locked", q[6], 1'b0);
        scc_core_model_i.set_brownout_sleep_off(1'b1);
        scc_core_model_i.xfer(1'b0, OFS_MICRO_CTRL, 32'h0, q, err);
        check("brownout_sleep_off_set", q[6], 1'b1);
        sleep_wake(3'h0, 7'h1E, 7, 1'b1, '0);
        sleep_wake(3'h2, 7'h00, 26, 1'b0, '0);
        $display("test brownout done");
    endtask
    initial begin
        #200us;
        fails++;
        finish_test();
    end
    initial begin
        t_div();
        t_modes();
        t_noop();
        t_bod();
        finish_test();
    end
endmodule // scc_sleep_ctrl_tb

// ### verilog/scc_clk_div.sv
// power-of-two system clock divider producing a clock-enable tick
// assumes sel is stable between register writes
module scc_clk_div
    import scc_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] sel,
    output logic tick
);

    if (CNT_W < 8) begin : g_chk
        $error("scc_clk_div: CNT_W must reach factor 256");
    end

    // free-running prescale counter
    logic [CNT_W-1:0] cnt_q;
    // low-order count mask for the selected factor
    logic [CNT_W-1:0] mask;
    // reserved codes saturate at the largest factor
    logic [3:0] eff_sel;

    assign eff_sel = (sel > CLKSEL_MAX) ? CLKSEL_MAX : sel;
    assign mask = CNT_W'((9'h001 << eff_sel) - 9'h001);
    assign tick = ((cnt_q & mask) == mask);

    // counter runs on every edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // one tick every two cycles when the factor is two
    property p_tick_gap;
        @(posedge pclk) disable iff (!presetn)
        (tick && sel == 4'h1 && $past(sel) == 4'h1) |=> !tick ##1 tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("divide by two gap wrong");

endmodule // scc_clk_div

// ### verilog/scc_pkg.sv
// package for the sleep and clock divide controller
// assumes a single 100 MHz pclk domain and an APB register port
package scc_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CLK_DIV = 8'h00;
    localparam logic [7:0] OFS_SLEEP_CTRL = 8'h04;
    localparam logic [7:0] OFS_MICRO_CTRL = 8'h08;
    localparam logic [7:0] OFS_CMP_CTRL = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    // field positions
    localparam int SLP_ALLOW_BIT = 0;
    localparam int SLP_MODE_LSB = 1;
    localparam int BROWNOUT_SLEEP_OFF_EN_BIT = 5;
    localparam int BROWNOUT_SLEEP_OFF_BIT = 6;
    localparam int CMP_OFF_BIT = 7;

    // values after reset, and the largest divide select
    localparam logic [3:0] CLKSEL_RST_PLAIN = 4'h0;
    localparam logic [3:0] CLKSEL_RST_DIV8 = 4'h3;
    localparam logic [3:0] CLKSEL_MAX = 4'h8;

    // timing, with the clock period in ns
    localparam int CLK_PERIOD_NS = 10;
    localparam int BOD_WAKE_NS = 60000;
    // least time, so round up
    localparam int BOD_WAKE_CYC_DFLT = (BOD_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STARTUP_CYC_DFLT = 6;
    localparam logic [15:0] STANDBY_WAKE_CYC = 16'h0006;
    localparam logic [15:0] FAST_WAKE_CYC = 16'h0001;
    localparam logic [2:0] HALT_CYC = 3'h4;
    localparam logic [2:0] TIMED_WIN_CYC = 3'h4;

    // controller states
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_SLEEP = 2'b01,
        ST_WAKE = 2'b10,
        ST_HALT = 2'b11
    } scc_state_e;

    // sleep mode select codes
    typedef enum logic [2:0] {
        MD_IDLE = 3'b000,
        MD_ADCQ = 3'b001,
        MD_PDOWN = 3'b010,
        MD_PSAVE = 3'b011,
        MD_RSV4 = 3'b100,
        MD_RSV5 = 3'b101,
        MD_STBY = 3'b110,
        MD_XSTBY = 3'b111
    } scc_mode_e;

    // wake-up sources
    typedef struct packed {
        logic ext_irq;
        logic pin_change;
        logic twi_match;
        logic wdt_irq;
        logic timer2_irq;
        logic spm_ready;
        logic adc_done;
        logic cmp_irq;
        logic other_io;
    } scc_wake_s;

    // clock domain and oscillator enables
    typedef struct packed {
        logic core;
        logic flash;
        logic io;
        logic adc;
        logic asy;
        logic main_osc;
        logic timer_osc;
    } scc_clk_s;

endpackage

// ### verilog/scc_sleep_ctrl.sv
// sleep and clock divide controller: APB registers, sleep state machine,
// clock gating, brown-out disable and wake-up sequencing
// assumes the core pulses sleep_instr for one cycle per sleep instruction
//
// The implementer's own choices: register access over APB and the address map.
module scc_sleep_ctrl
    import scc_pkg::*;
#(
    parameter int BOD_WAKE_CYC = BOD_WAKE_CYC_DFLT,
    parameter int STARTUP_CYC = STARTUP_CYC_DFLT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic divide_by_eight_fuse,
    input wire logic xtal_sel,
    input wire logic timer2_async,
    input wire logic adc_enable,
    input wire logic sleep_instr,
    input wire logic sys_reset_req,
    input wire scc_wake_s wake_src,
    output scc_clk_s clk_en,
    output logic div_tick,
    output logic bod_on,
    output logic core_hold,
    output logic irq_resume,
    output logic reset_vec_start,
    output logic adc_start,
    output logic comparator_pd
);

    if (BOD_WAKE_CYC < 1 || BOD_WAKE_CYC > 65535) begin : g_chk_bod
        $error("scc_sleep_ctrl: BOD_WAKE_CYC out of range");
    end
    if (STARTUP_CYC < 1 || STARTUP_CYC > 65535) begin : g_chk_su
        $error("scc_sleep_ctrl: STARTUP_CYC out of range");
    end

    localparam logic [15:0] BOD_CYC = 16'(BOD_WAKE_CYC);
    localparam logic [15:0] SU_CYC = 16'(STARTUP_CYC);

    // register state
    logic [3:0] clksel_q; // clock divide select
    logic fuse_pend_q; // fuse value still to be loaded
    logic sleep_allow_q; // sleep allow bit
    scc_mode_e mode_sel_q; // sleep mode select
    logic brownout_sleep_off_q; // brown-out sleep off bit
    logic [2:0] win_q; // timed write window, cycles left
    logic cmp_off_q; // comparator power off
    logic [31:0] prdata_q; // read data captured in setup

    // controller state
    scc_state_e state_q;
    scc_mode_e mode_q; // mode latched at entry
    logic bod_off_q; // detector switched off for this sleep
    logic [2:0] halt_cnt_q; // halt cycles left
    logic irq_resume_q;
    logic reset_vec_q;
    logic adc_start_q;

    // bus decode
    logic setup_ph;
    logic wr_acc;
    logic mapped;
    logic [31:0] rd_word;

    // sequencing
    logic enter;
    logic mode_ok;
    logic bod_elig;
    logic wake_hit;
    logic [15:0] wake_len;
    logic tmr_done;
    scc_wake_s wake_allow;

    assign setup_ph = psel & ~penable;
    assign wr_acc = psel & penable & pwrite;
    assign mapped = (paddr == OFS_CLK_DIV) || (paddr == OFS_SLEEP_CTRL) ||
        (paddr == OFS_MICRO_CTRL) || (paddr == OFS_CMP_CTRL) || (paddr == OFS_STATUS);
    // zero wait states, unmapped address answers with an error
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = prdata_q;

    // read multiplexer
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (paddr)
            OFS_CLK_DIV: rd_word[3:0] = clksel_q;
            OFS_SLEEP_CTRL: begin
                rd_word[SLP_ALLOW_BIT] = sleep_allow_q;
                rd_word[SLP_MODE_LSB +: 3] = mode_sel_q;
            end
            OFS_MICRO_CTRL: begin
                rd_word[BROWNOUT_SLEEP_OFF_BIT] = brownout_sleep_off_q;
                rd_word[BROWNOUT_SLEEP_OFF_EN_BIT] = (win_q != 3'h0);
            end
            OFS_CMP_CTRL: rd_word[CMP_OFF_BIT] = cmp_off_q;
            OFS_STATUS: begin
                rd_word[1:0] = state_q;
                rd_word[2] = bod_off_q;
                rd_word[5:3] = mode_q;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // read data held from setup through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup_ph && !pwrite) begin
            prdata_q <= rd_word;
        end
    end

    // clock divide select; fuse taken on the first edge after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clksel_q <= CLKSEL_RST_PLAIN;
            fuse_pend_q <= 1'b1;
        end else if (fuse_pend_q) begin
            fuse_pend_q <= 1'b0;
            clksel_q <= divide_by_eight_fuse ? CLKSEL_RST_DIV8 : CLKSEL_RST_PLAIN;
        end else if (wr_acc && paddr == OFS_CLK_DIV) begin
            clksel_q <= pwdata[3:0];
        end
    end

    // divided clock enable for the synchronous domains
    scc_clk_div #(
        .CNT_W(8)
    ) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .sel(clksel_q),
        .tick(div_tick)
    );

    // sleep control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_allow_q <= 1'b0;
            mode_sel_q <= MD_IDLE;
        end else if (wr_acc && paddr == OFS_SLEEP_CTRL) begin
            sleep_allow_q <= pwdata[SLP_ALLOW_BIT];
            mode_sel_q <= scc_mode_e'(pwdata[SLP_MODE_LSB +: 3]);
        end
    end

    // brown-out sleep off bit behind the timed sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brownout_sleep_off_q <= 1'b0;
            win_q <= 3'h0;
        end else if (wr_acc && paddr == OFS_MICRO_CTRL && win_q != 3'h0 &&
            !pwdata[BROWNOUT_SLEEP_OFF_EN_BIT]) begin
            brownout_sleep_off_q <= pwdata[BROWNOUT_SLEEP_OFF_BIT];
            win_q <= 3'h0;
        end else if (wr_acc && paddr == OFS_MICRO_CTRL && win_q == 3'h0 &&
            pwdata[BROWNOUT_SLEEP_OFF_EN_BIT] && pwdata[BROWNOUT_SLEEP_OFF_BIT]) begin
            win_q <= TIMED_WIN_CYC;
        end else if (win_q != 3'h0) begin
            // rewrites inside the window do not extend it
            win_q <= win_q - 3'h1;
        end
    end

    // comparator control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_off_q <= 1'b0;
        end else if (wr_acc && paddr == OFS_CMP_CTRL) begin
            cmp_off_q <= pwdata[CMP_OFF_BIT];
        end
    end
    assign comparator_pd = cmp_off_q;

    // modes that may really be entered
    always_comb begin
        unique case (mode_sel_q)
            MD_IDLE, MD_ADCQ, MD_PDOWN, MD_PSAVE: mode_ok = 1'b1;
            MD_STBY, MD_XSTBY: mode_ok = xtal_sel;
            MD_RSV4, MD_RSV5: mode_ok = 1'b0;
        endcase
    end

    assign enter = (state_q == ST_RUN) && sleep_instr && sleep_allow_q && mode_ok;
    // only deep modes may drop the detector
    assign bod_elig = (mode_sel_q == MD_PDOWN) || (mode_sel_q == MD_PSAVE) ||
        (mode_sel_q == MD_STBY) || (mode_sel_q == MD_XSTBY);

    // wake sources admitted per mode
    always_comb begin
        wake_allow = '0;
        wake_allow.ext_irq = 1'b1;
        wake_allow.pin_change = 1'b1;
        wake_allow.twi_match = 1'b1;
        wake_allow.wdt_irq = 1'b1;
        unique case (mode_q)
            MD_IDLE: begin
                wake_allow.timer2_irq = 1'b1;
                wake_allow.spm_ready = 1'b1;
                wake_allow.adc_done = 1'b1;
                wake_allow.other_io = 1'b1;
                wake_allow.cmp_irq = ~cmp_off_q;
            end
            MD_ADCQ: begin
                wake_allow.spm_ready = 1'b1;
                wake_allow.adc_done = 1'b1;
                wake_allow.timer2_irq = timer2_async;
            end
            MD_PSAVE, MD_XSTBY: wake_allow.timer2_irq = 1'b1;
            MD_PDOWN, MD_STBY, MD_RSV4, MD_RSV5: wake_allow.timer2_irq = 1'b0;
        endcase
    end
    assign wake_hit = |(wake_src & wake_allow);

    // start-up length for the mode being left
    always_comb begin
        unique case (mode_q)
            MD_IDLE, MD_ADCQ, MD_RSV4, MD_RSV5: wake_len = FAST_WAKE_CYC;
            MD_STBY, MD_XSTBY: wake_len = STANDBY_WAKE_CYC;
            MD_PDOWN, MD_PSAVE: wake_len = SU_CYC;
        endcase
        if (bod_off_q && BOD_CYC > wake_len) begin
            wake_len = BOD_CYC;
        end
    end

    // start-up interval timer
    scc_wake_timer #(
        .CW(16)
    ) u_tmr (
        .pclk(pclk),
        .presetn(presetn),
        .load(state_q == ST_SLEEP && wake_hit && !sys_reset_req),
        .load_val(wake_len),
        .busy(),
        .done(tmr_done)
    );

    // sleep state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_RUN;
            mode_q <= MD_IDLE;
            halt_cnt_q <= 3'h0;
        end else if (sys_reset_req && state_q != ST_RUN) begin
            // reset while asleep goes to the vector
            state_q <= ST_RUN;
        end else begin
            unique case (state_q)
                ST_RUN: begin
                    if (enter) begin
                        state_q <= ST_SLEEP;
                        mode_q <= mode_sel_q;
                    end
                end
                ST_SLEEP: begin
                    if (wake_hit) begin
                        state_q <= ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    if (tmr_done) begin
                        state_q <= ST_HALT;
                        halt_cnt_q <= HALT_CYC;
                    end
                end
                ST_HALT: begin
                    if (halt_cnt_q == 3'h1) begin
                        state_q <= ST_RUN;
                    end
                    halt_cnt_q <= halt_cnt_q - 3'h1;
                end
            endcase
        end
    end

    // detector switched off at entry, back on at wake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bod_off_q <= 1'b0;
        end else if (enter) begin
            bod_off_q <= brownout_sleep_off_q && bod_elig;
        end else if (state_q == ST_WAKE || state_q == ST_RUN) begin
            bod_off_q <= 1'b0;
        end
    end
    assign bod_on = ~bod_off_q || state_q != ST_SLEEP;

    // one-cycle core notifications
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_resume_q <= 1'b0;
            reset_vec_q <= 1'b0;
            adc_start_q <= 1'b0;
        end else begin
            irq_resume_q <= (state_q == ST_HALT) && (halt_cnt_q == 3'h1) && !sys_reset_req;
            reset_vec_q <= sys_reset_req && (state_q != ST_RUN);
            adc_start_q <= enter && adc_enable &&
                (mode_sel_q == MD_IDLE || mode_sel_q == MD_ADCQ);
        end
    end
    assign irq_resume = irq_resume_q;
    assign reset_vec_start = reset_vec_q;
    assign adc_start = adc_start_q;
    // core only held, never cleared, so its storage survives
    assign core_hold = (state_q != ST_RUN);

    // clock domain gating per state and mode
    always_comb begin
        clk_en = '1;
        clk_en.timer_osc = timer2_async;
        if (state_q != ST_RUN) begin
            // core and program memory clocks stop
            clk_en.core = 1'b0;
            clk_en.flash = 1'b0;
        end
        if (state_q == ST_SLEEP) begin
            unique case (mode_q)
                MD_IDLE: clk_en.io = 1'b1;
                MD_ADCQ: clk_en.io = 1'b0;
                MD_PDOWN: begin
                    clk_en.io = 1'b0;
                    clk_en.adc = 1'b0;
                    clk_en.asy = 1'b0;
                    clk_en.main_osc = 1'b0;
                    clk_en.timer_osc = 1'b0;
                end
                MD_PSAVE: begin
                    clk_en.io = 1'b0;
                    clk_en.adc = 1'b0;
                    clk_en.main_osc = 1'b0;
                end
                MD_STBY: begin
                    clk_en.io = 1'b0;
                    clk_en.adc = 1'b0;
                    clk_en.asy = 1'b0;
                    clk_en.timer_osc = 1'b0;
                end
                MD_XSTBY: begin
                    clk_en.io = 1'b0;
                    clk_en.adc = 1'b0;
                    clk_en.asy = timer2_async;
                end
                MD_RSV4, MD_RSV5: clk_en.io = 1'b1;
            endcase
        end
    end

    // halt phase lasts exactly four cycles then runs
    sequence s_halt4;
        (state_q == ST_HALT) [*4] ##1 (state_q == ST_RUN);
    endsequence
    property p_halt;
        @(posedge pclk) disable iff (!presetn || sys_reset_req)
        (state_q == ST_WAKE && tmr_done) |=> s_halt4;
    endproperty
    a_halt: assert property (p_halt) else $error("halt not four cycles");

    property p_noallow;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_RUN && sleep_instr && !sleep_allow_q) |=> state_q == ST_RUN;
    endproperty
    a_noallow: assert property (p_noallow) else $error("slept without allow");

    property p_idle_clk;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_SLEEP && mode_q == MD_IDLE) |-> !clk_en.core && !clk_en.flash &&
            clk_en.io && clk_en.adc;
    endproperty
    a_idle_clk: assert property (p_idle_clk) else $error("idle gating wrong");

    property p_pdown;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_SLEEP && mode_q == MD_PDOWN) |-> clk_en == '0;
    endproperty
    a_pdown: assert property (p_pdown) else $error("power-down clock left on");

    property p_bod_elig;
        @(posedge pclk) disable iff (!presetn)
        !bod_on |-> (mode_q != MD_IDLE && mode_q != MD_ADCQ);
    endproperty
    a_bod_elig: assert property (p_bod_elig) else $error("detector off in light mode");

    property p_bod_wake;
        @(posedge pclk) disable iff (!presetn || sys_reset_req)
        (state_q == ST_SLEEP && bod_off_q && wake_hit) |=>
            bod_on && (state_q == ST_WAKE) [*8];
    endproperty
    a_bod_wake: assert property (p_bod_wake) else $error("detector wake too short");

    property p_rst_wake;
        @(posedge pclk) disable iff (!presetn)
        (sys_reset_req && state_q == ST_SLEEP) |=> state_q == ST_RUN && reset_vec_start;
    endproperty
    a_rst_wake: assert property (p_rst_wake) else $error("reset did not wake");

    property p_adc_start;
        @(posedge pclk) disable iff (!presetn)
        (enter && adc_enable && mode_sel_q == MD_IDLE) |=> adc_start ##1 !adc_start;
    endproperty
    a_adc_start: assert property (p_adc_start) else $error("no conversion on idle");

endmodule // scc_sleep_ctrl

// ### verilog/scc_wake_timer.sv
// down counter that times the wake-up start-up interval
// assumes load values of at least one; done marks the last counted cycle
module scc_wake_timer
    import scc_pkg::*;
#(
    parameter int CW = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [CW-1:0] load_val,
    output logic busy,
    output logic done
);

    if (CW < 4) begin : g_chk
        $error("scc_wake_timer: CW too small");
    end

    // cycles left in the interval
    logic [CW-1:0] cnt_q;

    // load on request, else count to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= load_val;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign busy = (cnt_q != '0);
    assign done = (cnt_q == CW'(1));

endmodule // scc_wake_timer
